// >>> ssiv_defs.vh
// Constants for the speech-synthesis interrupt vectoring block.
// Assumes a single 250 MHz clock and a 32-bit AXI4-Lite register bus.
`ifndef SSIV_DEFS_VH
`define SSIV_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define SSIV_OFS_MODE1        8'h00
`define SSIV_OFS_MODE2        8'h04
`define SSIV_OFS_PPC0_RELOAD  8'h08
`define SSIV_OFS_PPC1_RELOAD  8'h0c
`define SSIV_OFS_STATUS       8'h10
`define SSIV_OFS_SAMPLE       8'h14
`define SSIV_OFS_VECTOR       8'h18

// ****************************************
// Field positions
// ****************************************
`define SSIV_M1_LPC           0
`define SSIV_M1_PCM           1
`define SSIV_M1_IO_MAP        2
`define SSIV_M2_PPC0_UFL      0
`define SSIV_M2_PPC1_UFL      1
`define SSIV_M2_DUAL          2
`define SSIV_ST_FLAG          0
`define SSIV_ST_L1_PEND       1
`define SSIV_ST_L2_PEND       2

// ****************************************
// Reset values
// ****************************************
`define SSIV_MODE1_RST        8'h00
`define SSIV_MODE2_RST        8'h00
`define SSIV_PPC_RST          16'h0000
`define SSIV_SAMPLE_RST       16'h0000

// ****************************************
// Vectors and counts
// ****************************************
`define SSIV_VEC_L2_BASE      16'h0010
`define SSIV_VEC_L1_BASE      16'h0018
`define SSIV_PPC_FLOOR        16'h0200
`define SSIV_L1_INSTR_CYCLES  30
`define SSIV_CLK_HZ           250000000
`define SSIV_LPC_RATE_HZ      20000
`define SSIV_LPC_DIV          (`SSIV_CLK_HZ / `SSIV_LPC_RATE_HZ)

// ****************************************
// Bus responses
// ****************************************
`define SSIV_RESP_OKAY        2'b00
`define SSIV_RESP_SLVERR      2'b10

`endif

// >>> ssiv_core.v
// Interrupt pacing, vector selection, mode registers, pitch period counters
// and synthesis sample register of a speech-synthesis processor core.
// Assumes the core pulses instr_cycle once per instruction and int_ack on
// interrupt entry; all inputs are synchronous to aclk.
//
// Added by the designer: the AXI4-Lite register port and the address map.
`include "ssiv_defs.vh"
`default_nettype none

module ssiv_core #(
  parameter integer LPC_DIV = `SSIV_LPC_DIV
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address and data
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Core events
  input  wire        instr_cycle,
  input  wire        power_down_instr,
  input  wire        init_n,
  input  wire        lvl2_req,
  input  wire        int_ack,
  input  wire        load_synth_sample_instr,
  input  wire [15:0] sample_in,
  // Interrupt and mode outputs
  output wire        int_req,
  output reg  [15:0] int_vector,
  output wire        lpc_tick,
  output wire        io_map_en,
  output wire        pcm_overflow
);

  // ****************************************
  // Helpers
  // ****************************************
  function [15:0] vec_sel;
    input [15:0] base;
    input        pcm;
    input        lpc;
    begin
      vec_sel = base + {13'h0000, pcm, lpc, 1'b0};
    end
  endfunction

  // Byte lanes beyond a register's width are ignored rather than refused.
  function [7:0] strb8;
    input [7:0] old;
    input [31:0] wd;
    input [3:0] st;
    begin
      strb8 = st[0] ? wd[7:0] : old;
    end
  endfunction

  function [15:0] strb16;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] st;
    begin
      strb16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // ****************************************
  // Register state
  // ****************************************
  reg  [7:0]  mode1_reg;
  reg  [7:0]  mode2_reg;
  reg  [15:0] ppc0_reload_reg;
  reg  [15:0] ppc1_reload_reg;
  reg  [15:0] ppc0_reg;
  reg  [15:0] ppc1_reg;
  reg  [15:0] sample_reg;
  reg         status_reg;
  reg         l1_pend_reg;
  reg         l2_pend_reg;
  reg  [4:0]  instr_cnt_reg;
  reg  [15:0] lpc_div_reg;
  reg  [31:0] rdata_next;
  reg         rd_hit;

  wire        lpc_on  = mode1_reg[`SSIV_M1_LPC];
  wire        pcm_on  = mode1_reg[`SSIV_M1_PCM];
  wire        wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire        rd_fire = s_axi_arvalid & ~s_axi_rvalid;
  wire        wr_hit  = (s_axi_awaddr == `SSIV_OFS_MODE1) |
                        (s_axi_awaddr == `SSIV_OFS_MODE2) |
                        (s_axi_awaddr == `SSIV_OFS_PPC0_RELOAD) |
                        (s_axi_awaddr == `SSIV_OFS_PPC1_RELOAD) |
                        (s_axi_awaddr == `SSIV_OFS_STATUS);
  wire        wr_m1   = wr_fire & (s_axi_awaddr == `SSIV_OFS_MODE1);
  wire        wr_m2   = wr_fire & (s_axi_awaddr == `SSIV_OFS_MODE2);
  wire        wr_st   = wr_fire & (s_axi_awaddr == `SSIV_OFS_STATUS) & s_axi_wstrb[0];

  // ****************************************
  // Bus handshakes
  // ****************************************
  // Address and data are taken together so no half-written state is held.
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_arready = rd_fire;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SSIV_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `SSIV_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
    end else begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `SSIV_RESP_OKAY : `SSIV_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdata_next;
        s_axi_rresp  <= rd_hit ? `SSIV_RESP_OKAY : `SSIV_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read multiplexer
  // ****************************************
  // Unmapped offsets read as zero and answer with an error response.
  always @* begin
    rdata_next = 32'h00000000;
    rd_hit     = 1'b1;
    case (s_axi_araddr)
      `SSIV_OFS_MODE1:       rdata_next = {24'h000000, mode1_reg};
      `SSIV_OFS_MODE2:       rdata_next = {24'h000000, mode2_reg};
      `SSIV_OFS_PPC0_RELOAD: rdata_next = {16'h0000, ppc0_reload_reg};
      `SSIV_OFS_PPC1_RELOAD: rdata_next = {16'h0000, ppc1_reload_reg};
      `SSIV_OFS_STATUS:      rdata_next = {29'h00000000, l2_pend_reg, l1_pend_reg, status_reg};
      `SSIV_OFS_SAMPLE:      rdata_next = {16'h0000, sample_reg};
      `SSIV_OFS_VECTOR:      rdata_next = {16'h0000, int_vector};
      default:               rd_hit     = 1'b0;
    endcase
  end

  // ****************************************
  // Mode registers
  // ****************************************
  // two 8-bit modes
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode1_reg       <= `SSIV_MODE1_RST;
      ppc0_reload_reg <= `SSIV_PPC_RST;
      ppc1_reload_reg <= `SSIV_PPC_RST;
    end else begin
      if (wr_m1) begin
        mode1_reg <= strb8(mode1_reg, s_axi_wdata, s_axi_wstrb);
      end
      if (wr_fire && s_axi_awaddr == `SSIV_OFS_PPC0_RELOAD) begin
        ppc0_reload_reg <= strb16(ppc0_reload_reg, s_axi_wdata, s_axi_wstrb);
      end
      if (wr_fire && s_axi_awaddr == `SSIV_OFS_PPC1_RELOAD) begin
        ppc1_reload_reg <= strb16(ppc1_reload_reg, s_axi_wdata, s_axi_wstrb);
      end
    end
  end

  assign io_map_en = mode1_reg[`SSIV_M1_IO_MAP];

  // ****************************************
  // Pitch period counters
  // ****************************************
  // A reload value below the floor only underflows after the counter wraps,
  // so software is expected to load at least the floor value.
  wire ppc0_ufl = instr_cycle & lpc_on & (ppc0_reg == `SSIV_PPC_FLOOR);
  wire ppc1_ufl = instr_cycle & lpc_on & mode2_reg[`SSIV_M2_DUAL] &
                  (ppc1_reg == `SSIV_PPC_FLOOR);

  always @(posedge aclk) begin
    if (!aresetn) begin
      ppc0_reg <= `SSIV_PPC_RST;
      ppc1_reg <= `SSIV_PPC_RST;
    end else begin
      if (!lpc_on) begin
        ppc0_reg <= ppc0_reload_reg;
      end else if (instr_cycle) begin
        ppc0_reg <= ppc0_ufl ? ppc0_reload_reg : ppc0_reg - 16'h0001;
      end
      if (!lpc_on || !mode2_reg[`SSIV_M2_DUAL]) begin
        ppc1_reg <= ppc1_reload_reg;
      end else if (instr_cycle) begin
        ppc1_reg <= ppc1_ufl ? ppc1_reload_reg : ppc1_reg - 16'h0001;
      end
    end
  end

  // An underflow in the clearing cycle survives the write.
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode2_reg <= `SSIV_MODE2_RST;
    end else begin
      if (wr_m2 && s_axi_wstrb[0]) begin
        mode2_reg[`SSIV_M2_DUAL]     <= s_axi_wdata[`SSIV_M2_DUAL];
        mode2_reg[`SSIV_M2_PPC0_UFL] <= mode2_reg[`SSIV_M2_PPC0_UFL] &
                                        ~s_axi_wdata[`SSIV_M2_PPC0_UFL];
        mode2_reg[`SSIV_M2_PPC1_UFL] <= mode2_reg[`SSIV_M2_PPC1_UFL] &
                                        ~s_axi_wdata[`SSIV_M2_PPC1_UFL];
      end
      if (ppc0_ufl) begin
        mode2_reg[`SSIV_M2_PPC0_UFL] <= 1'b1;
      end
      if (ppc1_ufl) begin
        mode2_reg[`SSIV_M2_PPC1_UFL] <= 1'b1;
      end
    end
  end

  // ****************************************
  // Interrupt pacing
  // ****************************************
  // The window counter restarts whenever LPC is switched on, so the first
  // level 1 interrupt comes a full window after the enable.
  localparam integer L1_LAST = `SSIV_L1_INSTR_CYCLES - 1;

  wire l1_tick = lpc_on & instr_cycle & (instr_cnt_reg == L1_LAST[4:0]);

  always @(posedge aclk) begin
    if (!aresetn || !lpc_on) begin
      instr_cnt_reg <= 5'h00;
    end else if (instr_cycle) begin
      instr_cnt_reg <= l1_tick ? 5'h00 : instr_cnt_reg + 5'h01;
    end
  end

  // The tick is combinational so the level 2 request lands on the wrapping edge.
  // 20 kHz divider
  assign lpc_tick = lpc_on & (lpc_div_reg == LPC_DIV[15:0] - 16'h0001);

  always @(posedge aclk) begin
    if (!aresetn || !lpc_on) begin
      lpc_div_reg <= 16'h0000;
    end else begin
      lpc_div_reg <= lpc_tick ? 16'h0000 : lpc_div_reg + 16'h0001;
    end
  end

  // Level 2 wins when both are pending; it has the lower vectors.
  assign int_req = l1_pend_reg | l2_pend_reg;

  // A new request in the cycle of its acknowledge keeps the level pending.
  always @(posedge aclk) begin
    if (!aresetn) begin
      l1_pend_reg <= 1'b0;
      l2_pend_reg <= 1'b0;
    end else begin
      l2_pend_reg <= lvl2_req | lpc_tick | (l2_pend_reg & ~int_ack);
      l1_pend_reg <= l1_tick | (l1_pend_reg & ~(int_ack & ~l2_pend_reg));
    end
  end

  // ****************************************
  // Vector selection
  // ****************************************
  always @* begin
    if (l2_pend_reg) begin
      int_vector = vec_sel(`SSIV_VEC_L2_BASE, pcm_on, lpc_on);
    end else begin
      int_vector = vec_sel(`SSIV_VEC_L1_BASE, pcm_on, lpc_on);
    end
  end

  // ****************************************
  // Status flag
  // ****************************************
  // A set cause in the clearing cycle wins so that no event is lost.
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= 1'b0;
    end else begin
      if (power_down_instr || !init_n || (int_ack && int_req)) begin
        status_reg <= 1'b1;
      end else if (wr_st && s_axi_wdata[`SSIV_ST_FLAG]) begin
        status_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Synthesis sample register
  // ****************************************
  // The low two bits are forced to zero so they never carry stale input bits.
  // sample layout
  always @(posedge aclk) begin
    if (!aresetn) begin
      sample_reg <= `SSIV_SAMPLE_RST;
    end else if (load_synth_sample_instr) begin
      sample_reg <= {sample_in[15:2], 2'b00};
    end
  end

  assign pcm_overflow = (sample_reg[15:14] != {2{sample_reg[13]}});

endmodule // ssiv_core

`default_nettype wire

// >>> ssiv_core_assertions.sv
// Assertion checker for ssiv_core, bound to the core's ports.
// Assumes one clock domain and a synchronous active-low reset.
`include "ssiv_defs.vh"
`default_nettype none
module ssiv_chk #(
  parameter integer LPC_DIV = 12500
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Core events and outputs
  input wire logic        load_synth_sample_instr,
  input wire logic [15:0] sample_in,
  input wire logic        int_req,
  input wire logic [15:0] int_vector,
  input wire logic        lpc_tick,
  input wire logic        io_map_en,
  input wire logic        pcm_overflow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] gap_reg;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************************
  // Properties
  // ****************************************
  // Saturates so that a long spell with LPC off cannot wrap into a false gap.
  always_ff @(posedge aclk) begin
    if (!aresetn)
      gap_reg <= 16'hffff;
    else if (lpc_tick)
      gap_reg <= 16'h0000;
    else if (gap_reg != 16'hffff)
      gap_reg <= gap_reg + 16'h0001;
  end
  property p_l2_vec;
    lpc_tick |=> int_req && int_vector[15:3] == 13'h0002 && int_vector[1:0] == 2'b10;
  endproperty
  a_l2_vec: assert property (p_l2_vec) else $error("tick vector wrong");
  property p_vec_rng;
    int_req |-> int_vector[15:5] == 11'h000 && int_vector[4] && !int_vector[0];
  endproperty
  a_vec_rng: assert property (p_vec_rng) else $error("vector out of range");
  property p_gap;
    lpc_tick |-> gap_reg >= LPC_DIV - 1;
  endproperty
  a_gap: assert property (p_gap) else $error("ticks too close");
  property p_wr_ans;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_io_map;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wstrb[0]
      && s_axi_awaddr == `SSIV_OFS_MODE1 |=> io_map_en == $past(s_axi_wdata[2]);
  endproperty
  a_io_map: assert property (p_io_map) else $error("io map bit wrong");
  property p_ovf;
    load_synth_sample_instr |=>
      pcm_overflow == ($past(sample_in[15:14]) != {2{$past(sample_in[13])}});
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
endmodule // ssiv_chk

bind ssiv_core ssiv_chk #(.LPC_DIV(LPC_DIV)) i_ssiv_chk (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .load_synth_sample_instr, .sample_in, .int_req, .int_vector, .lpc_tick,
  .io_map_en, .pcm_overflow
);
`default_nettype wire

// >>> ssiv_core_test.sv
// Self-checking bench for ssiv_core over its register bus and event pins.
// Assumes the bound checker; a short LPC_DIV keeps the run brief.
`include "ssiv_defs.vh"
`default_nettype none
module ssiv_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer DIV = 3000;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [5:0]  ev = 6'h00;
  logic [15:0] sample_in = 16'h0, int_vector;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        int_req, lpc_tick, io_map_en, pcm_overflow;
  logic [31:0] q_d[$], q_m[$];
  logic [1:0]  q_r[$], q_b[$];
  int          n_mismatch = 0, checked = 0, i, k, t;

  ssiv_core #(.LPC_DIV(DIV)) i_ssiv_core (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .instr_cycle(ev[0]),
    .power_down_instr(ev[1]), .init_n(~ev[5]), .lvl2_req(ev[2]), .int_ack(ev[3]),
    .load_synth_sample_instr(ev[4]), .sample_in, .int_req, .int_vector,
    .lpc_tick, .io_map_en, .pcm_overflow
  );

  initial forever #2 aclk = ~aclk;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task tally_and_finish;
    $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task tmo;
    if (t >= 100) begin
      n_mismatch++;
      tally_and_finish();
    end
    @(posedge aclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    q_b.push_back(r);
    t = 0;
    do @(posedge aclk); while (s_axi_awready !== 1'b1 && ++t < 100);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    tmo();
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff,
          input logic [1:0] r = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    q_d.push_back(e & m);
    q_m.push_back(m);
    q_r.push_back(r);
    t = 0;
    do @(posedge aclk); while (s_axi_arready !== 1'b1 && ++t < 100);
    s_axi_arvalid <= 1'b0;
    tmo();
  endtask

  task pulse(input int s, input int n);
    ev[s] <= 1'b1;
    repeat (n) @(posedge aclk);
    ev[s] <= 1'b0;
    @(posedge aclk);
  endtask

  // Answers are compared here; the ready lines stall at random meanwhile.
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
      chk("rdata", q_d[0], s_axi_rdata & q_m[0]);
      chk("rresp", {30'h0, q_r[0]}, {30'h0, s_axi_rresp});
      q_d.delete(0);
      q_m.delete(0);
      q_r.delete(0);
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
      chk("bresp", {30'h0, q_b[0]}, {30'h0, s_axi_bresp});
      q_b.delete(0);
    end
    if (!s_axi_rready || s_axi_rvalid)
      s_axi_rready <= 1'($urandom);
    if (!s_axi_bready || s_axi_bvalid)
      s_axi_bready <= 1'($urandom);
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    k = $urandom(32'h23704b32);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`SSIV_OFS_MODE1, 32'h0);
    rd(`SSIV_OFS_MODE2, 32'h0);
    rd(8'h1c, 32'h0, 32'hffffffff, `SSIV_RESP_SLVERR);
    wr(8'h1c, 32'hffffffff, `SSIV_RESP_SLVERR);
    wr(`SSIV_OFS_MODE1, 32'hffffff04);
    chk("io_map_en", 32'h1, {31'h0, io_map_en});
    rd(`SSIV_OFS_MODE1, 32'h4, 32'hffffff07);
    for (i = 1; i < 6; i += 4) begin
      pulse(i, 1);
      rd(`SSIV_OFS_STATUS, 32'h1, 32'h1);
      wr(`SSIV_OFS_STATUS, 32'h1);
      rd(`SSIV_OFS_STATUS, 32'h0, 32'h1);
    end
    for (i = 0; i < 4; i++) begin
      wr(`SSIV_OFS_MODE1, {30'h0, i[1], 1'b1});
      pulse(0, 29);
      rd(`SSIV_OFS_STATUS, 32'h0, 32'h6);
      pulse(0, 1);
      rd(`SSIV_OFS_STATUS, 32'h2, 32'h6);
      wr(`SSIV_OFS_MODE1, 32'(i));
      pulse(2, 1);
      chk("int_req", 32'h1, {31'h0, int_req});
      chk("int_vector", 32'h10 + 32'(2 * i), {16'h0, int_vector});
      rd(`SSIV_OFS_VECTOR, 32'h10 + 32'(2 * i));
      pulse(3, 1);
      rd(`SSIV_OFS_VECTOR, 32'h18 + 32'(2 * i));
      chk("int_vector", 32'h18 + 32'(2 * i), {16'h0, int_vector});
      pulse(3, 1);
      chk("int_req", 32'h0, {31'h0, int_req});
      rd(`SSIV_OFS_STATUS, 32'h1, 32'h7);
      wr(`SSIV_OFS_STATUS, 32'h1);
    end
    wr(`SSIV_OFS_MODE1, 32'h0);
    k = $urandom_range(4, 1);
    wr(`SSIV_OFS_PPC0_RELOAD, 32'h200 + 32'(k));
    wr(`SSIV_OFS_PPC1_RELOAD, 32'h201 + 32'(k));
    wr(`SSIV_OFS_MODE2, 32'h4);
    wr(`SSIV_OFS_MODE1, 32'h1);
    chk("io_map_en", 32'h0, {31'h0, io_map_en});
    pulse(0, k);
    rd(`SSIV_OFS_MODE2, 32'h4, 32'h7);
    pulse(0, 1);
    rd(`SSIV_OFS_MODE2, 32'h5, 32'h7);
    pulse(0, 1);
    rd(`SSIV_OFS_MODE2, 32'h7, 32'h7);
    wr(`SSIV_OFS_MODE2, 32'h7);
    rd(`SSIV_OFS_MODE2, 32'h4, 32'h7);
    for (i = 0; i < 6; i++) begin
      sample_in <= 16'($urandom);
      pulse(4, 1);
      chk("pcm_overflow", {31'h0, sample_in[15:14] != {2{sample_in[13]}}},
          {31'h0, pcm_overflow});
      rd(`SSIV_OFS_SAMPLE, {16'h0, sample_in[15:2], 2'b00});
    end
    t = 0;
    do @(posedge aclk); while (lpc_tick !== 1'b1 && ++t < 2 * DIV);
    if (t >= 2 * DIV) n_mismatch++;
    t = 0;
    do @(posedge aclk); while (lpc_tick !== 1'b1 && ++t < 2 * DIV);
    chk("tick gap", 32'(DIV - 1), 32'(t));
    for (t = 0; t < 100 && q_d.size() + q_b.size() > 0; t++) @(posedge aclk);
    if (q_d.size() + q_b.size() > 0) n_mismatch++;
    tally_and_finish();
  end
endmodule // ssiv_core_test
`default_nettype wire
